// ===== verilog/sfsr_pkg.sv
package sfsr_pkg;

  // ---------------------------------------------------------------
  // Pin and configuration carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic hold_reset_n;
  } sfsr_pins_t;

  typedef struct packed {
    logic quad_enable;
    logic wp_pin_en;
    logic hold_pin_en;
    logic reset_pin_en;
    logic io23_data_en;
    logic [6:0] drive_pct;
    logic [3:0] dummy_eb;
    logic [3:0] dummy_ed;
    logic [4:0] block_protect;
    logic complement_protect;
  } sfsr_cfg_t;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_ENABLE_CMD_EN = 8'h06;
  localparam logic [7:0] CMD_WR_DIS = 8'h04;
  localparam logic [7:0] CMD_VOL_WE = 8'h50;
  localparam logic [7:0] CMD_SRW1 = 8'h01;
  localparam logic [7:0] CMD_SRW2 = 8'h31;
  localparam logic [7:0] CMD_SRW3 = 8'h11;
  localparam logic [7:0] CMD_SRR1 = 8'h05;
  localparam logic [7:0] CMD_SRR2 = 8'h35;
  localparam logic [7:0] CMD_SRR3 = 8'h15;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROG = 8'h32;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLK32_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLK64_ERASE = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] CMD_INFO_ERASE = 8'h44;
  localparam logic [7:0] CMD_INFO_PROG = 8'h42;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_RST_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RST_DEVICE = 8'h99;

  // ---------------------------------------------------------------
  // Register layout and defaults
  // ---------------------------------------------------------------
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] SR3_RESET = 8'h40;
  localparam logic [7:0] SR1_WMASK = 8'hFC;
  localparam logic [7:0] SR2_WMASK = 8'h7B;
  localparam logic [7:0] SR3_WMASK = 8'hE0;
  localparam logic [7:0] SR2_OTP_MASK = 8'h38;
  localparam int SR2_QE_POS = 1;
  localparam int SR2_LOCK_POS = 3;
  localparam int SR2_CMP_POS = 6;
  localparam int SR1_PROTECT_SELECT_LO_POS = 7;
  localparam int SR2_PROTECT_SELECT_HI_POS = 0;
  localparam int SR3_PINSEL_POS = 7;
  localparam int ADDR_AREA_LSB = 12;
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 24;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int PROG_TIME_US = 16;
  localparam int ERASE_TIME_US = 100;
  localparam int SRW_TIME_US = 30;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int SRW_CYCLES = SRW_TIME_US * CLK_MHZ;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_ADDR = 5'h04,
    ST_DATA = 5'h08,
    ST_READ = 5'h10
  } sfsr_state_t;

endpackage : sfsr_pkg

// ===== verilog/sfsr_status_bank.sv
`timescale 1ns/1ns
module sfsr_status_bank
  import sfsr_pkg::*;
#(
  parameter int PROG_LEN = PROG_CYCLES,
  parameter int ERASE_LEN = ERASE_CYCLES,
  parameter int SRW_LEN = SRW_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sfsr_pins_t pins,
  input wire logic op_fail,
  input wire logic region_protected,
  output logic so_data,
  output logic so_en_n,
  output logic busy,
  output sfsr_cfg_t cfg
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] reg_sel(input logic [7:0] c);
    reg_sel = (c == CMD_SRW2 || c == CMD_SRR2) ? 2'h1 :
              (c == CMD_SRW3 || c == CMD_SRR3) ? 2'h2 : 2'h0;
  endfunction : reg_sel

  function automatic logic is_pe(input logic [7:0] c);
    is_pe = c == CMD_PAGE_PROG || c == CMD_QUAD_PROG || c == CMD_SECT_ERASE ||
            c == CMD_BLK32_ERASE || c == CMD_BLK64_ERASE || c == CMD_INFO_ERASE ||
            c == CMD_INFO_PROG || c == CMD_CHIP_ERASE_A || c == CMD_CHIP_ERASE_B;
  endfunction : is_pe

  function automatic logic is_erase(input logic [7:0] c);
    is_erase = c == CMD_SECT_ERASE || c == CMD_BLK32_ERASE || c == CMD_BLK64_ERASE ||
               c == CMD_INFO_ERASE || c == CMD_CHIP_ERASE_A || c == CMD_CHIP_ERASE_B;
  endfunction : is_erase

  function automatic logic is_chip(input logic [7:0] c);
    is_chip = c == CMD_CHIP_ERASE_A || c == CMD_CHIP_ERASE_B;
  endfunction : is_chip

  function automatic logic is_info(input logic [7:0] c);
    is_info = c == CMD_INFO_ERASE || c == CMD_INFO_PROG;
  endfunction : is_info

  function automatic logic is_srw(input logic [7:0] c);
    is_srw = c == CMD_SRW1 || c == CMD_SRW2 || c == CMD_SRW3;
  endfunction : is_srw

  function automatic logic is_srr(input logic [7:0] c);
    is_srr = c == CMD_SRR1 || c == CMD_SRR2 || c == CMD_SRR3;
  endfunction : is_srr

  function automatic logic busy_ok(input logic [7:0] c);
    busy_ok = is_srr(c) || c == CMD_RST_ENABLE || c == CMD_RST_DEVICE ||
              c == CMD_SUSPEND;
  endfunction : busy_ok

  // ---------------------------------------------------------------
  // Pin synchronisers and edges
  // ---------------------------------------------------------------
  sfsr_pins_t pin_meta_reg;
  sfsr_pins_t pin_sync_reg;
  sfsr_pins_t pin_prev_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta_reg <= 5'h1B;
      pin_sync_reg <= 5'h1B;
      pin_prev_reg <= 5'h1B;
    end else begin
      pin_meta_reg <= pins;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  wire logic sel_on = ~pin_sync_reg.cs_n;
  wire logic cs_fall = pin_prev_reg.cs_n & ~pin_sync_reg.cs_n;
  wire logic cs_rise = ~pin_prev_reg.cs_n & pin_sync_reg.cs_n;
  wire logic sck_rise = sel_on & pin_sync_reg.sck & ~pin_prev_reg.sck;
  wire logic sck_fall = sel_on & ~pin_sync_reg.sck & pin_prev_reg.sck;

  // ---------------------------------------------------------------
  // Frame decoder
  // ---------------------------------------------------------------
  sfsr_state_t st_reg;
  sfsr_state_t st_next;
  logic [4:0] bit_cnt_reg;
  logic [7:0] in_shift_reg;
  logic [7:0] cmd_reg;
  logic [7:0] data_reg;
  logic [ADDR_BITS-1:0] addr_reg;
  logic cmd_live_reg;
  logic addr_ok_reg;
  logic data_ok_reg;
  logic busy_reg;

  wire logic [7:0] in_next = {in_shift_reg[6:0], pin_sync_reg.si};
  wire logic cmd_done = (st_reg == ST_CMD) && sck_rise && bit_cnt_reg == 5'(CMD_BITS - 1);
  wire logic addr_done = (st_reg == ST_ADDR) && sck_rise && bit_cnt_reg == 5'(ADDR_BITS - 1);
  wire logic data_done = (st_reg == ST_DATA) && sck_rise && bit_cnt_reg == 5'(CMD_BITS - 1);
  wire logic cmd_accept = cmd_done && (~busy_reg || busy_ok(in_next));

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: st_next = ST_IDLE;
      ST_CMD: begin
        if (cmd_done) begin
          if (!cmd_accept) st_next = ST_IDLE;
          else if (is_pe(in_next)) st_next = ST_ADDR;
          else if (is_srw(in_next)) st_next = ST_DATA;
          else if (is_srr(in_next)) st_next = ST_READ;
          else st_next = ST_IDLE;
        end
      end
      ST_ADDR: if (addr_done) st_next = ST_DATA;
      ST_DATA: st_next = ST_DATA;
      ST_READ: st_next = ST_READ;
      default: st_next = ST_IDLE;
    endcase
    if (cs_fall) st_next = ST_CMD;
    else if (!sel_on) st_next = ST_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      bit_cnt_reg <= 5'h00;
      in_shift_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      in_shift_reg <= sck_rise ? in_next : in_shift_reg;
      if (cs_fall || cmd_done || addr_done || data_done) bit_cnt_reg <= 5'h00;
      else if (sck_rise && bit_cnt_reg != 5'h1F) bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || cs_fall) begin
      cmd_reg <= 8'h00;
      cmd_live_reg <= 1'b0;
      addr_reg <= '0;
      addr_ok_reg <= 1'b0;
      data_reg <= 8'h00;
      data_ok_reg <= 1'b0;
    end else begin
      if (cmd_done) cmd_reg <= in_next;
      if (cmd_done) cmd_live_reg <= cmd_accept;
      if (st_reg == ST_ADDR && sck_rise) addr_reg <= {addr_reg[ADDR_BITS-2:0], pin_sync_reg.si};
      if (addr_done) addr_ok_reg <= 1'b1;
      if (data_done && !data_ok_reg) data_reg <= in_next;
      if (data_done) data_ok_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Status state
  // ---------------------------------------------------------------
  logic [2:0][7:0] nv_reg;
  logic [2:0][7:0] vol_reg;
  logic wel_reg;
  logic vwe_reg;
  logic rst_en_reg;
  logic program_suspended_flag_reg;
  logic erase_suspended_flag_reg;
  logic protected_access_error_reg;
  logic program_erase_failure_reg;
  logic op_erase_reg;
  logic op_pe_reg;
  logic [15:0] op_cnt_reg;

  function automatic logic [7:0] wmask(input logic [1:0] s);
    wmask = (s == 2'h1) ? SR2_WMASK : (s == 2'h2) ? SR3_WMASK : SR1_WMASK;
  endfunction : wmask

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                       input logic [1:0] s);
    logic [7:0] otp;
    otp = (s == 2'h1) ? SR2_OTP_MASK : 8'h00;
    merge = (old & ~wmask(s)) | (d & wmask(s)) | (old & otp);
  endfunction : merge

  // Live status view, volatile copy with hardware flags, SR3 bits 1:0 from the nonvolatile copy
  function automatic logic [7:0] view(input logic [1:0] s);
    case (s)
      2'h1: view = {erase_suspended_flag_reg, vol_reg[1][6:3], program_suspended_flag_reg, vol_reg[1][1:0]};
      2'h2: view = {vol_reg[2][7:5], 1'b0, program_erase_failure_reg, protected_access_error_reg, nv_reg[2][1:0]};
      default: view = {vol_reg[0][7:2], wel_reg, busy_reg};
    endcase
  endfunction : view

  // ---------------------------------------------------------------
  // Command execution at frame end
  // ---------------------------------------------------------------
  wire logic exec = cs_rise && cmd_live_reg;
  wire logic [1:0] wsel = reg_sel(cmd_reg);
  wire logic do_write_enable_cmd = exec && cmd_reg == CMD_WRITE_ENABLE_CMD_EN;
  wire logic do_write_disable_cmd = exec && cmd_reg == CMD_WR_DIS;
  wire logic do_vwe = exec && cmd_reg == CMD_VOL_WE;
  wire logic do_srw = exec && is_srw(cmd_reg) && data_ok_reg && !busy_reg;
  wire logic wp_low = ~pin_sync_reg.wp_n & ~cfg.quad_enable;
  wire logic protect_select_lo = nv_reg[0][SR1_PROTECT_SELECT_LO_POS];
  wire logic protect_select_hi = nv_reg[1][SR2_PROTECT_SELECT_HI_POS];
  wire logic sr_locked = protect_select_hi | (protect_select_lo & wp_low);
  wire logic [7:0] vol_new = merge(vol_reg[wsel], data_reg, wsel);
  wire logic [7:0] nv_new = merge(nv_reg[wsel], data_reg, wsel);
  wire logic srw_vol = do_srw && vwe_reg && !sr_locked && vol_new != vol_reg[wsel];
  wire logic srw_nv = do_srw && !vwe_reg && wel_reg && !sr_locked &&
                      nv_new != nv_reg[wsel];

  wire logic do_pe = exec && is_pe(cmd_reg) && addr_ok_reg && !busy_reg;
  wire logic [1:0] area = addr_reg[ADDR_AREA_LSB+1:ADDR_AREA_LSB];
  wire logic lock_hit = is_info(cmd_reg) &&
                        (area == 2'h0 || nv_reg[1][SR2_LOCK_POS + int'(area) - 1]);
  wire logic bp_set = |vol_reg[0][6:2];
  wire logic prot_hit = (is_chip(cmd_reg) && bp_set) ||
                        (!is_info(cmd_reg) && region_protected) || lock_hit;
  wire logic pe_try = do_pe && wel_reg && !program_suspended_flag_reg && !erase_suspended_flag_reg;
  wire logic start_pe = pe_try && !prot_hit;
  wire logic op_done = busy_reg && op_cnt_reg == 16'h0001;
  wire logic do_susp = exec && cmd_reg == CMD_SUSPEND && busy_reg && op_pe_reg;
  wire logic do_resume = exec && cmd_reg == CMD_RESUME && (program_suspended_flag_reg || erase_suspended_flag_reg);
  wire logic hw_reset = cfg.reset_pin_en && !pin_sync_reg.hold_reset_n;
  wire logic sw_reset = hw_reset || (exec && cmd_reg == CMD_RST_DEVICE && rst_en_reg);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wel_reg <= 1'b0;
    end else if (sw_reset || do_write_disable_cmd || op_done) begin
      wel_reg <= 1'b0;
    end else if (do_write_enable_cmd) begin
      wel_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vwe_reg <= 1'b0;
      rst_en_reg <= 1'b0;
    end else if (exec) begin
      vwe_reg <= do_vwe;
      rst_en_reg <= cmd_reg == CMD_RST_ENABLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nv_reg <= {SR3_RESET, SR2_RESET, SR1_RESET};
      vol_reg <= {SR3_RESET, SR2_RESET, SR1_RESET};
    end else if (sw_reset) begin
      vol_reg <= nv_reg;
    end else if (srw_nv) begin
      nv_reg[wsel] <= nv_new;
      vol_reg[wsel] <= nv_new;
    end else if (srw_vol) begin
      vol_reg[wsel] <= vol_new;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || sw_reset) begin
      busy_reg <= 1'b0;
      op_cnt_reg <= 16'h0000;
      op_pe_reg <= 1'b0;
      op_erase_reg <= 1'b0;
      program_suspended_flag_reg <= 1'b0;
      erase_suspended_flag_reg <= 1'b0;
    end else if (srw_nv || start_pe) begin
      busy_reg <= 1'b1;
      op_pe_reg <= start_pe;
      op_erase_reg <= start_pe && is_erase(cmd_reg);
      op_cnt_reg <= !start_pe ? 16'(SRW_LEN) :
                    is_erase(cmd_reg) ? 16'(ERASE_LEN) : 16'(PROG_LEN);
    end else if (do_susp) begin
      busy_reg <= 1'b0;
      program_suspended_flag_reg <= !op_erase_reg;
      erase_suspended_flag_reg <= op_erase_reg;
    end else if (do_resume) begin
      busy_reg <= 1'b1;
      program_suspended_flag_reg <= 1'b0;
      erase_suspended_flag_reg <= 1'b0;
    end else if (busy_reg) begin
      busy_reg <= !op_done;
      op_cnt_reg <= op_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || sw_reset) begin
      protected_access_error_reg <= 1'b0;
      program_erase_failure_reg <= 1'b0;
    end else begin
      if (pe_try && prot_hit) protected_access_error_reg <= 1'b1;
      if (op_done && op_pe_reg && op_fail) program_erase_failure_reg <= 1'b1;
      else if (start_pe) program_erase_failure_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Serial read-out
  // ---------------------------------------------------------------
  logic [2:0] rd_cnt_reg;
  logic [7:0] rd_shift_reg;
  logic so_reg;
  wire logic [7:0] live_byte = view(reg_sel(cmd_reg));

  always_ff @(posedge sys_clk) begin
    if (rst || cs_fall) begin
      rd_cnt_reg <= 3'h0;
      rd_shift_reg <= 8'h00;
      so_reg <= 1'b0;
    end else if (st_reg == ST_READ && sck_fall) begin
      rd_cnt_reg <= rd_cnt_reg + 3'h1;
      so_reg <= (rd_cnt_reg == 3'h0) ? live_byte[7] : rd_shift_reg[7];
      rd_shift_reg <= (rd_cnt_reg == 3'h0) ? {live_byte[6:0], 1'b0} :
                      {rd_shift_reg[6:0], 1'b0};
    end
  end

  assign so_data = so_reg;
  assign so_en_n = st_reg != ST_READ;
  assign busy = busy_reg;

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  wire logic [1:0] ods = vol_reg[2][6:5];
  wire logic [1:0] dcf = nv_reg[2][1:0];
  wire logic qe = vol_reg[1][SR2_QE_POS];

  assign cfg.quad_enable = qe;
  assign cfg.io23_data_en = qe;
  assign cfg.wp_pin_en = ~qe;
  assign cfg.hold_pin_en = ~qe & ~vol_reg[2][SR3_PINSEL_POS];
  assign cfg.reset_pin_en = ~qe & vol_reg[2][SR3_PINSEL_POS];
  assign cfg.drive_pct = (ods == 2'h0) ? 7'h64 : (ods == 2'h1) ? 7'h4B :
                         (ods == 2'h2) ? 7'h32 : 7'h19;
  assign cfg.dummy_eb = (dcf == 2'h0) ? 4'h6 : (dcf == 2'h1) ? 4'h4 :
                        (dcf == 2'h2) ? 4'h8 : 4'hA;
  assign cfg.dummy_ed = (dcf == 2'h0) ? 4'hA : (dcf == 2'h1) ? 4'h8 :
                        (dcf == 2'h2) ? 4'h4 : 4'h6;
  assign cfg.block_protect = vol_reg[0][6:2];
  assign cfg.complement_protect = vol_reg[1][SR2_CMP_POS];

endmodule : sfsr_status_bank

// ===== bench/sfsr_status_bank_properties.sv
`timescale 1ns/1ns
module sfsr_status_bank_properties
  import sfsr_pkg::*;
#(
  parameter int PROG_LEN = PROG_CYCLES,
  parameter int ERASE_LEN = ERASE_CYCLES,
  parameter int SRW_LEN = SRW_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sfsr_pins_t pins,
  input wire logic op_fail,
  input wire logic region_protected,
  input wire logic so_data,
  input wire logic so_en_n,
  input wire logic busy,
  input wire sfsr_cfg_t cfg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Busy length counter
  // ---------------------------------------------------------------
  int busy_cnt;
  always_ff @(posedge sys_clk) begin
    busy_cnt <= (rst || !busy) ? 0 : busy_cnt + 1;
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_reset_cfg;
    disable iff (1'b0) rst |=> !busy && so_en_n && cfg.drive_pct == 7'h32 && !cfg.quad_enable;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("reset defaults wrong");
  property p_busy_min;
    $rose(busy) |-> busy [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_max;
    busy_cnt <= PROG_LEN + ERASE_LEN + SRW_LEN;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy never ends");
  property p_busy_start;
    $rose(busy) |-> pins.cs_n && $past(pins.cs_n, 2);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not at frame end");
  property p_quad_pins;
    cfg.quad_enable |-> cfg.io23_data_en && !cfg.wp_pin_en && !cfg.hold_pin_en && !cfg.reset_pin_en;
  endproperty
  a_quad_pins: assert property (p_quad_pins) else $error("quad pin map wrong");
  property p_shared_pins;
    !cfg.quad_enable |-> cfg.wp_pin_en && !cfg.io23_data_en && cfg.hold_pin_en != cfg.reset_pin_en;
  endproperty
  a_shared_pins: assert property (p_shared_pins) else $error("shared pin map wrong");
  property p_drive_code;
    cfg.drive_pct inside {7'h64, 7'h4B, 7'h32, 7'h19};
  endproperty
  a_drive_code: assert property (p_drive_code) else $error("drive value illegal");
  property p_dummy_pair;
    {cfg.dummy_eb, cfg.dummy_ed} inside {8'h6A, 8'h48, 8'h84, 8'hA6};
  endproperty
  a_dummy_pair: assert property (p_dummy_pair) else $error("dummy pair illegal");
  property p_dummy_fixed;
    $stable(cfg.dummy_eb) && $stable(cfg.dummy_ed);
  endproperty
  a_dummy_fixed: assert property (p_dummy_fixed) else $error("dummy field changed");
  property p_so_hold;
    pins.sck && $past(pins.sck) && $past(pins.sck, 2) && $past(pins.sck, 3) |-> $stable(so_data);
  endproperty
  a_so_hold: assert property (p_so_hold) else $error("serial out moved in high phase");
  property p_idle_out;
    pins.cs_n && $past(pins.cs_n, 2) && $past(pins.cs_n, 4) |-> so_en_n;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("output on while deselected");
endmodule : sfsr_status_bank_properties

bind sfsr_status_bank sfsr_status_bank_properties #(
  .PROG_LEN(PROG_LEN), .ERASE_LEN(ERASE_LEN), .SRW_LEN(SRW_LEN)
) chk_u (.sys_clk(sys_clk), .rst(rst), .pins(pins), .op_fail(op_fail),
  .region_protected(region_protected), .so_data(so_data), .so_en_n(so_en_n),
  .busy(busy), .cfg(cfg));

// ===== bench/sfsr_host.sv
`timescale 1ns/1ns
module sfsr_host
  import sfsr_pkg::*;
(
  output sfsr_pins_t pins,
  input wire logic so_data
);
  initial begin
    pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, hold_reset_n: 1'b1};
  end
  // Mode 0 frame, clock parked low, si toggles after each falling edge
  task automatic frame(input logic [7:0] cmd, input int nbits, input logic [23:0] tx,
                       output logic [7:0] rx);
    logic [31:0] sh;
    sh = {cmd, tx << (24 - nbits)};
    rx = 8'h00;
    pins.cs_n = 1'b0;
    for (int i = 0; i < 8 + nbits; i++) begin
      pins.si = sh[31];
      sh = sh << 1;
      #200;
      pins.sck = 1'b1;
      if (i >= 8) rx = {rx[6:0], so_data};
      #400;
      pins.sck = 1'b0;
      pins.si = ~pins.si;
      #200;
    end
    #200;
    pins.cs_n = 1'b1;
    #1000;
  endtask : frame
endmodule : sfsr_host

// ===== bench/test_serial_flash_status_registers.sv
`timescale 1ns/1ns
module test_serial_flash_status_registers;
  import sfsr_pkg::*;
  localparam int LEN = 400;
  logic sys_clk;
  logic rst;
  logic op_fail;
  logic region_protected;
  sfsr_pins_t pins;
  logic so_data;
  logic so_en_n;
  logic busy;
  sfsr_cfg_t cfg;
  int failures;
  int compares;
  int cycles;
  int seed;
  int s1;
  int s2;
  int s3;
  logic [7:0] rx;
  logic [7:0] d;
  logic [7:0] codes [7] = '{CMD_PAGE_PROG, CMD_QUAD_PROG, CMD_SECT_ERASE, CMD_BLK32_ERASE,
                            CMD_BLK64_ERASE, CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B};

  sfsr_status_bank #(.PROG_LEN(LEN), .ERASE_LEN(LEN), .SRW_LEN(LEN)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .pins(pins), .op_fail(op_fail),
    .region_protected(region_protected), .so_data(so_data), .so_en_n(so_en_n),
    .busy(busy), .cfg(cfg));
  sfsr_host host_u (.pins(pins), .so_data(so_data));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end

  // Frames start on a falling edge, so every pin change lands off the sampling edge
  task automatic send(input logic [7:0] c, input int n, input logic [23:0] v);
    @(negedge sys_clk);
    host_u.frame(c, n, v, rx);
  endtask : send

  task automatic rd(input logic [7:0] c, input int e);
    @(negedge sys_clk);
    host_u.frame(c, 8, 24'h000000, rx);
    check($sformatf("read %h", c), rx, 8'(e));
  endtask : rd

  task automatic wait_idle();
    for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge sys_clk);
    check("busy end", {7'h00, busy}, 8'h00);
  endtask : wait_idle

  initial begin
    rst = 1'b1;
    op_fail = 1'b0;
    region_protected = 1'b0;
    cycles = 0;
    seed = 31;
    s1 = 0;
    s2 = 0;
    s3 = 8'h40;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    rd(CMD_SRR1, s1);
    rd(CMD_SRR2, s2);
    rd(CMD_SRR3, s3);
    check("dummy", {cfg.dummy_eb, cfg.dummy_ed}, 8'h6A);
    $display("Test defaults done");
    send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
    rd(CMD_SRR1, 2);
    send(CMD_WR_DIS, 0, 24'h0);
    rd(CMD_SRR1, 0);
    $display("Test latch done");
    d = (8'($random(seed)) & 8'h7C) | 8'h06;
    send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
    send(CMD_SRW1, 8, {16'h0000, d});
    check("busy start", {7'h00, busy}, 8'h01);
    send(CMD_WR_DIS, 0, 24'h0);
    rd(CMD_SRR1, (d & 8'h7C) | 8'h03);
    wait_idle();
    s1 = d & 8'h7C;
    rd(CMD_SRR1, s1);
    send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
    send(CMD_SRW1, 8, {16'h0000, 8'(s1)});
    check("equal busy", {7'h00, busy}, 8'h00);
    rd(CMD_SRR1, s1 | 2);
    send(CMD_WR_DIS, 0, 24'h0);
    s1 = ~s1 & 8'h7C;
    send(CMD_VOL_WE, 0, 24'h0);
    send(CMD_SRW1, 8, {16'h0000, 8'(s1)});
    wait_idle();
    rd(CMD_SRR1, s1);
    check("bp", {3'h0, cfg.block_protect}, 8'(s1 >> 2));
    $display("Test status one done");
    d = (8'($random(seed)) & 8'h42) | 8'h08;
    send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
    send(CMD_SRW2, 8, {16'h0000, d});
    wait_idle();
    rd(CMD_SRR2, d);
    check("quad", {7'h00, cfg.quad_enable}, {7'h00, d[1]});
    check("cmp", {7'h00, cfg.complement_protect}, {7'h00, d[6]});
    send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
    send(CMD_SRW2, 8, 24'h000000);
    wait_idle();
    rd(CMD_SRR2, 8'h08);
    $display("Test status two done");
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      d[6:0] = {2'(k), 5'h1F};
      send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
      send(CMD_SRW3, 8, {16'h0000, d});
      wait_idle();
      s3 = (s3 & 8'h1F) | (d & 8'hE0);
      rd(CMD_SRR3, s3);
      check("drive", {1'b0, cfg.drive_pct}, 8'(100 - 25 * k));
      check("pin sel", {7'h00, cfg.reset_pin_en}, {7'h00, d[7]});
    end
    $display("Test status three done");
    send(CMD_PAGE_PROG, 24, 24'h000100);
    check("no latch", {7'h00, busy}, 8'h00);
    @(negedge sys_clk) region_protected = 1'b1;
    send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
    send(CMD_PAGE_PROG, 24, 24'h000100);
    wait_idle();
    @(negedge sys_clk) region_protected = 1'b0;
    send(CMD_WR_DIS, 0, 24'h0);
    s3 = s3 | 8'h04;
    rd(CMD_SRR3, s3);
    @(negedge sys_clk) op_fail = 1'b1;
    send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
    send(CMD_PAGE_PROG, 24, 24'h000200);
    wait_idle();
    @(negedge sys_clk) op_fail = 1'b0;
    s3 = s3 | 8'h08;
    rd(CMD_SRR3, s3);
    rd(CMD_SRR1, s1);
    // Suspend a program, then an erase, and resume each to completion
    for (int k = 0; k < 2; k++) begin
      send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
      send(k == 0 ? CMD_PAGE_PROG : CMD_SECT_ERASE, 24, 24'h000300);
      send(CMD_SUSPEND, 0, 24'h0);
      check("suspend", {7'h00, busy}, 8'h00);
      rd(CMD_SRR2, k == 0 ? 8'h0C : 8'h88);
      send(CMD_RESUME, 0, 24'h0);
      check("resume", {7'h00, busy}, 8'h01);
      wait_idle();
      rd(CMD_SRR2, 8'h08);
    end
    for (int k = 0; k < 9; k++) begin
      send(CMD_WRITE_ENABLE_CMD_EN, 0, 24'h0);
      if (k < 7) send(codes[k], 24, 24'($random(seed)) & 24'h0FFFFF);
      else send(CMD_INFO_PROG, 24, k == 7 ? 24'h002000 : 24'h001000);
      d = (k == 8 || (k > 4 && k < 7 && (s1 & 8'h7C) != 0)) ? 8'h00 : 8'h01;
      check("op start", {7'h00, busy}, d);
      wait_idle();
    end
    send(CMD_WR_DIS, 0, 24'h0);
    s3 = s3 & 8'hF7;
    rd(CMD_SRR3, s3);
    $display("Test operations done");
    stop_test();
  end
endmodule : test_serial_flash_status_registers
